// File: hdl/hmd_engine.sv
// Four-channel host bus-master DMA engine with consolidated host flags.
// Assumes a PCI master datapath that moves beats and fetches descriptors.
`timescale 1ns/1ps
`include "hmd_defs.svh"

module hmd_engine
  import hmd_pkg::*;
#(
  parameter int NCH = 4,
  parameter int CW  = 24
)(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  // Register port (word index: sel, channel, reg)
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_gsel_i,
  input  wire logic [1:0]  reg_chan_i,
  input  wire logic [2:0]  reg_idx_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic [31:0]      reg_rdata_o,
  // Master datapath: data beats
  output logic [NCH-1:0]   beat_req_o,
  output logic [31:0]      beat_addr_o,
  input  wire logic [NCH-1:0] beat_done_i,
  input  wire logic [2:0]  beat_bytes_i,
  // Master datapath: descriptor fetch
  output logic             desc_req_o,
  output logic [1:0]       desc_chan_o,
  output logic [31:0]      desc_addr_o,
  input  wire logic        desc_valid_i,
  input  wire logic [31:0] desc_data_i,
  // Other host event sources
  input  wire logic [3:0]  mbox_evt_i,
  input  wire logic        gpio_wake_i,
  input  wire logic        codec_wake_i,
  input  wire logic        master_abort_i,
  input  wire logic        target_abort_i,
  // Host side status
  output logic             inta_n_o,
  output logic             pci_retry_o,
  output logic [1:0]       func_count_o,
  output logic             cfg_locked_o
);

  // ****************************************************************
  // Channel state
  // ****************************************************************
  logic [31:0]   base_addr_q [NCH];
  logic [31:0]   cur_addr_q  [NCH];
  logic [31:0]   base_cnt_q  [NCH];
  logic [CW-1:0] cur_cnt_q   [NCH];
  logic [CW-1:0] irq_base_q  [NCH];
  logic [CW-1:0] irq_cnt_q   [NCH];
  logic [15:0]   ctrl_q      [NCH];
  hmd_state_t    state_q     [NCH];
  logic          desc_flag_q [NCH];
  logic          desc_eol_q  [NCH];
  logic [15:0]   irq_flags_q;
  logic [15:0]   link_ctrl_q;
  logic [1:0]    fetch_owner_q;
  logic          fetch_busy_q;
  hmd_dword_t    fetch_word_q;
  logic [NCH-1:0] chan_irq;

  // Channel register write decode, shared by every channel
  function automatic logic chan_wr(input logic [1:0] ch,
                                   input logic [2:0] idx);
    chan_wr = reg_wr_i && !reg_gsel_i && reg_chan_i == ch
              && reg_idx_i == idx;
  endfunction

  // ****************************************************************
  // Per-channel sequencers
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      logic [CW-1:0] step;
      logic          fetch_mine;
      assign step       = CW'(beat_bytes_i);
      assign fetch_mine = fetch_busy_q && fetch_owner_q == 2'(g)
                          && desc_valid_i;
      assign beat_req_o[g] = state_q[g] == HMD_XFER;
      assign chan_irq[g] = |(ctrl_q[g][11:9] & ctrl_q[g][5:3]);

      // Sequencer and all channel registers
      always_ff @(posedge core_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          base_addr_q[g] <= 32'h0;
          cur_addr_q[g]  <= 32'h0;
          base_cnt_q[g]  <= 32'h0;
          cur_cnt_q[g]   <= '0;
          irq_base_q[g]  <= '0;
          irq_cnt_q[g]   <= '0;
          ctrl_q[g]      <= 16'h0;
          state_q[g]     <= HMD_IDLE;
          desc_flag_q[g] <= 1'b0;
          desc_eol_q[g]  <= 1'b0;
        end
        else
        begin
          // Software writes
          if (chan_wr(2'(g), `HMD_R_BASE_ADDR))
            base_addr_q[g] <= reg_wdata_i;
          if (chan_wr(2'(g), `HMD_R_CUR_ADDR))
            cur_addr_q[g] <= reg_wdata_i;
          if (chan_wr(2'(g), `HMD_R_BASE_CNT))
            base_cnt_q[g] <= reg_wdata_i;
          if (chan_wr(2'(g), `HMD_R_CUR_CNT))
            cur_cnt_q[g] <= reg_wdata_i[CW-1:0];
          if (chan_wr(2'(g), `HMD_R_IRQ_BASE))
            irq_base_q[g] <= reg_wdata_i[CW-1:0];
          if (chan_wr(2'(g), `HMD_R_IRQ_CNT))
            irq_cnt_q[g] <= reg_wdata_i[CW-1:0];
          if (chan_wr(2'(g), `HMD_R_CTRL))
          begin
            // Enables written, status bits write-one-to-clear
            ctrl_q[g][5:0]  <= reg_wdata_i[5:0];
            ctrl_q[g][11:8] <= ctrl_q[g][11:8] & ~reg_wdata_i[11:8];
          end
          // Start written last arms the channel
          case (state_q[g])
            HMD_IDLE:
            begin
              if (chan_wr(2'(g), `HMD_R_CTRL)
                  && reg_wdata_i[`HMD_C_START])
              begin
                if (reg_wdata_i[`HMD_C_SG_MODE])
                begin
                  cur_addr_q[g] <= base_addr_q[g];
                  state_q[g]    <= HMD_FETA;
                end
                else
                begin
                  state_q[g] <= HMD_XFER;
                end
              end
            end
            HMD_FETA:
            begin
              if (fetch_mine)
              begin
                base_cnt_q[g] <= desc_data_i;
                state_q[g]    <= HMD_FETB;
              end
            end
            HMD_FETB:
            begin
              if (fetch_mine)
              begin
                cur_cnt_q[g]   <= desc_data_i[CW-1:0];
                desc_eol_q[g]  <= desc_data_i[`HMD_D_EOL];
                desc_flag_q[g] <= desc_data_i[`HMD_D_FLAG];
                state_q[g]     <= HMD_XFER;
              end
            end
            HMD_XFER:
            begin
              if (beat_done_i[g])
              begin
                cur_cnt_q[g]  <= cur_cnt_q[g] - step;
                if (cur_cnt_q[g] <= step)
                  state_q[g] <= HMD_NEXT;
                // Descriptor mode keeps the table pointer still
                if (ctrl_q[g][`HMD_C_SG_MODE])
                  base_cnt_q[g] <= base_cnt_q[g] + 32'(beat_bytes_i);
                else
                  cur_addr_q[g] <= cur_addr_q[g] + 32'(beat_bytes_i);
              end
            end
            HMD_NEXT:
            begin
              if (!ctrl_q[g][`HMD_C_SG_MODE])
              begin
                // Circular end of buffer
                ctrl_q[g][`HMD_C_WRAP_ST] <= 1'b1;
                if (ctrl_q[g][`HMD_C_LOOP])
                begin
                  cur_addr_q[g] <= base_addr_q[g];
                  cur_cnt_q[g]  <= base_cnt_q[g][CW-1:0];
                  state_q[g]    <= HMD_XFER;
                end
                else
                  state_q[g] <= HMD_IDLE;
              end
              else
              begin
                if (desc_flag_q[g] && ctrl_q[g][`HMD_C_FLAG_IE])
                  ctrl_q[g][`HMD_C_FLAG_ST] <= 1'b1;
                if (desc_eol_q[g])
                begin
                  if (ctrl_q[g][`HMD_C_EOL_IE])
                    ctrl_q[g][`HMD_C_EOL_ST] <= 1'b1;
                  ctrl_q[g][`HMD_C_WRAP_ST] <= 1'b1;
                  if (ctrl_q[g][`HMD_C_LOOP])
                  begin
                    cur_addr_q[g] <= base_addr_q[g];
                    state_q[g]    <= HMD_FETA;
                  end
                  else
                    state_q[g] <= HMD_IDLE;
                end
                else
                begin
                  cur_addr_q[g] <= cur_addr_q[g] + `HMD_D_STRIDE;
                  state_q[g]    <= HMD_FETA;
                end
              end
            end
            default: state_q[g] <= HMD_IDLE;
          endcase
          // Software stop overrides every state change
          if (chan_wr(2'(g), `HMD_R_CTRL)
              && !reg_wdata_i[`HMD_C_START])
            state_q[g] <= HMD_IDLE;
          // Byte interrupt counter with reload
          if (state_q[g] == HMD_XFER && beat_done_i[g])
          begin
            if (irq_cnt_q[g] <= step)
            begin
              irq_cnt_q[g] <= irq_base_q[g];
              if (ctrl_q[g][`HMD_C_CNT_IE])
                ctrl_q[g][`HMD_C_CNT_ST] <= 1'b1;
            end
            else
              irq_cnt_q[g] <= irq_cnt_q[g] - step;
          end
          ctrl_q[g][`HMD_C_ACTIVE] <= state_q[g] != HMD_IDLE;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Descriptor fetch arbiter
  // ****************************************************************
  logic [1:0] fetch_pick;
  logic       fetch_any;

  // Lowest waiting channel wins the fetch slot
  always_comb
  begin
    fetch_pick = 2'h0;
    fetch_any  = 1'b0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (state_q[i] == HMD_FETA || state_q[i] == HMD_FETB)
      begin
        fetch_pick = 2'(i);
        fetch_any  = 1'b1;
      end
    end
  end

  // Holds the owner while its word is outstanding
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fetch_busy_q  <= 1'b0;
      fetch_owner_q <= 2'h0;
      fetch_word_q  <= HMD_DW_ADDR;
    end
    else if (fetch_busy_q)
    begin
      if (desc_valid_i)
        fetch_busy_q <= 1'b0;
    end
    else if (fetch_any)
    begin
      fetch_busy_q  <= 1'b1;
      fetch_owner_q <= fetch_pick;
      fetch_word_q  <= state_q[fetch_pick] == HMD_FETB ? HMD_DW_CNT
                                                       : HMD_DW_ADDR;
    end
  end

  assign desc_req_o  = fetch_busy_q;
  assign desc_chan_o = fetch_owner_q;
  assign desc_addr_o = cur_addr_q[fetch_owner_q]
                       + (fetch_word_q == HMD_DW_CNT ? 32'h4 : 32'h0);
  assign beat_addr_o = cur_addr_q[0];

  // ****************************************************************
  // Consolidated host flags and control
  // ****************************************************************
  logic [15:0] irq_set;
  logic        g_wr;

  assign g_wr = reg_wr_i && reg_gsel_i == `HMD_G_SEL;

  // Source map of the flag register
  always_comb
  begin
    irq_set = 16'h0;
    irq_set[`HMD_I_CHAN0 +: 4] = chan_irq;
    irq_set[`HMD_I_MBOX0 +: 4] = mbox_evt_i;
    irq_set[`HMD_I_GPIO_WAKE]  = gpio_wake_i;
    irq_set[`HMD_I_CODEC_WAKE] = codec_wake_i;
    irq_set[`HMD_I_MABORT]     = master_abort_i;
    irq_set[`HMD_I_TABORT]     = target_abort_i;
  end

  // Sticky flags; a set in the clear cycle wins
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      irq_flags_q <= `HMD_IRQ_RST;
    else
    begin
      if (g_wr && reg_idx_i == `HMD_G_IRQ_FLAGS)
        irq_flags_q <= (irq_flags_q & ~reg_wdata_i[15:0]
                        | irq_set) & `HMD_I_VALID;
      else
        irq_flags_q <= (irq_flags_q | irq_set) & `HMD_I_VALID;
    end
  end

  // Control locks once ready is set
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      link_ctrl_q <= `HMD_L_RST;
    else if (g_wr && reg_idx_i == `HMD_G_LINK_CTRL
             && !link_ctrl_q[`HMD_L_READY])
      link_ctrl_q <= {13'h0, reg_wdata_i[2:0]};
  end

  assign inta_n_o     = ~(|irq_flags_q);
  assign pci_retry_o  = ~link_ctrl_q[`HMD_L_READY];
  assign func_count_o = link_ctrl_q[1:0];
  assign cfg_locked_o = link_ctrl_q[`HMD_L_READY];

  // ****************************************************************
  // Read-back
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_o <= 32'h0;
    else if (reg_rd_i)
    begin
      reg_rdata_o <= 32'h0;
      if (reg_gsel_i)
      begin
        if (reg_idx_i == `HMD_G_IRQ_FLAGS)
          reg_rdata_o <= {16'h0, irq_flags_q};
        else if (reg_idx_i == `HMD_G_LINK_CTRL)
          reg_rdata_o <= {16'h0, link_ctrl_q};
      end
      else
      begin
        case (reg_idx_i)
          `HMD_R_BASE_ADDR: reg_rdata_o <= base_addr_q[reg_chan_i];
          `HMD_R_CUR_ADDR:  reg_rdata_o <= cur_addr_q[reg_chan_i];
          `HMD_R_BASE_CNT:  reg_rdata_o <= base_cnt_q[reg_chan_i];
          `HMD_R_CUR_CNT:   reg_rdata_o <= 32'(cur_cnt_q[reg_chan_i]);
          `HMD_R_IRQ_BASE:  reg_rdata_o <= 32'(irq_base_q[reg_chan_i]);
          `HMD_R_IRQ_CNT:   reg_rdata_o <= 32'(irq_cnt_q[reg_chan_i]);
          `HMD_R_CTRL:      reg_rdata_o <= {16'h0, ctrl_q[reg_chan_i]};
          default:          reg_rdata_o <= 32'h0;
        endcase
      end
    end
  end

endmodule // hmd_engine

// File: hdl/hmd_defs.svh
// Constants for the host bus-master DMA engine: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the engine file.
`ifndef HMD_DEFS_SVH
`define HMD_DEFS_SVH

// ****************************************************************
// Channel register indices (per channel, 8 words)
// ****************************************************************
`define HMD_R_BASE_ADDR   3'h0
`define HMD_R_CUR_ADDR    3'h1
`define HMD_R_BASE_CNT    3'h2
`define HMD_R_CUR_CNT     3'h3
`define HMD_R_IRQ_BASE    3'h4
`define HMD_R_IRQ_CNT     3'h5
`define HMD_R_CTRL        3'h6

// ****************************************************************
// Global register indices and global block select
// ****************************************************************
`define HMD_G_IRQ_FLAGS   3'h0
`define HMD_G_LINK_CTRL   3'h1
`define HMD_G_SEL         1'b1

// ****************************************************************
// Channel control/status bit positions
// ****************************************************************
`define HMD_C_START       0
`define HMD_C_SG_MODE     1
`define HMD_C_LOOP        2
`define HMD_C_EOL_IE      3
`define HMD_C_FLAG_IE     4
`define HMD_C_CNT_IE      5
`define HMD_C_WRAP_ST     8
`define HMD_C_EOL_ST      9
`define HMD_C_FLAG_ST     10
`define HMD_C_CNT_ST      11
`define HMD_C_ACTIVE      12

// ****************************************************************
// Descriptor fields (second word) and table entry stride
// ****************************************************************
`define HMD_D_EOL         31
`define HMD_D_FLAG        30
`define HMD_D_STRIDE      32'h0000_0008

// ****************************************************************
// Interrupt flag positions, control fields, reset values
// ****************************************************************
`define HMD_I_CHAN0       1
`define HMD_I_MBOX0       5
`define HMD_I_GPIO_WAKE   11
`define HMD_I_CODEC_WAKE  12
`define HMD_I_MABORT      13
`define HMD_I_TABORT      14
`define HMD_I_VALID       16'h79fe
`define HMD_L_READY       2
`define HMD_L_RST         16'h0000
`define HMD_IRQ_RST       16'h0000

`endif

// File: hdl/hmd_pkg.sv
// Types for the host bus-master DMA engine.
// Assumes hmd_defs.svh is on the include path.
package hmd_pkg;
  `include "hmd_defs.svh"

  // Engine sequencing states
  typedef enum logic [2:0] {
    HMD_IDLE  = 3'b000,
    HMD_FETA  = 3'b001,
    HMD_FETB  = 3'b010,
    HMD_XFER  = 3'b011,
    HMD_NEXT  = 3'b100
  } hmd_state_t;

  // Descriptor fetch word select
  typedef enum logic {
    HMD_DW_ADDR = 1'b0,
    HMD_DW_CNT  = 1'b1
  } hmd_dword_t;
endpackage

// File: tb/hmd_engine_props.sv
// Checker for the host-side outputs of the DMA engine.
// Assumes it is bound to hmd_engine and sees only its ports.
`timescale 1ns/1ps
module hmd_engine_props (
  // Clock and reset
  input logic        core_clk_i,
  input logic        arst_n_i,
  // Register port
  input logic        reg_wr_i,
  input logic        reg_gsel_i,
  input logic [2:0]  reg_idx_i,
  input logic [31:0] reg_wdata_i,
  // Descriptor fetch
  input logic        desc_req_o,
  input logic        desc_valid_i,
  input logic [31:0] desc_addr_o,
  // Event sources
  input logic [3:0]  mbox_evt_i,
  input logic        gpio_wake_i,
  input logic        codec_wake_i,
  input logic        master_abort_i,
  input logic        target_abort_i,
  // Host status
  input logic        inta_n_o,
  input logic        pci_retry_o,
  input logic [1:0]  func_count_o,
  input logic        cfg_locked_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  // ****************************************************************
  // Decoded writes and events
  // ****************************************************************
  logic wr_flags;
  logic wr_link;
  logic any_evt;
  assign wr_flags = reg_wr_i && reg_gsel_i && reg_idx_i == 3'h0;
  assign wr_link  = reg_wr_i && reg_gsel_i && reg_idx_i == 3'h1;
  assign any_evt  = (|mbox_evt_i) || gpio_wake_i || codec_wake_i ||
                    master_abort_i || target_abort_i;

  // ****************************************************************
  // Properties
  // ****************************************************************
  sequence s_word_a;
    desc_req_o && desc_valid_i && !desc_addr_o[2] && !reg_wr_i;
  endsequence
  sequence s_word_b;
    desc_req_o && desc_addr_o == $past(desc_addr_o, 2) + 32'h4;
  endsequence
  property p_fetch_pair;
    s_word_a |-> ##2 s_word_b;
  endproperty
  a_fetch_pair: assert property (p_fetch_pair)
    else $error("second descriptor word not at next word");
  property p_desc_hold;
    desc_req_o && !desc_valid_i && !reg_wr_i |=>
      desc_req_o && $stable(desc_addr_o);
  endproperty
  a_desc_hold: assert property (p_desc_hold)
    else $error("descriptor request dropped before answer");
  property p_lock_sticky;
    cfg_locked_o |=> cfg_locked_o;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("ready bit returned to zero");
  property p_retry;
    pci_retry_o == !cfg_locked_o;
  endproperty
  a_retry: assert property (p_retry)
    else $error("retry does not follow ready bit");
  property p_lock_refuse;
    cfg_locked_o && wr_link |=> $stable(func_count_o);
  endproperty
  a_lock_refuse: assert property (p_lock_refuse)
    else $error("locked control register changed");
  property p_func_write;
    !cfg_locked_o && wr_link |=>
      func_count_o == $past(reg_wdata_i[1:0]) &&
      cfg_locked_o == $past(reg_wdata_i[2]);
  endproperty
  a_func_write: assert property (p_func_write)
    else $error("control write not taken");
  property p_evt_line;
    any_evt |=> !inta_n_o;
  endproperty
  a_evt_line: assert property (p_evt_line)
    else $error("event did not assert interrupt line");
  property p_zero_keep;
    wr_flags && reg_wdata_i[15:0] == 16'h0 && !inta_n_o |=> !inta_n_o;
  endproperty
  a_zero_keep: assert property (p_zero_keep)
    else $error("zero write cleared a flag");
endmodule // hmd_engine_props

bind hmd_engine hmd_engine_props u_props (
  .core_clk_i, .arst_n_i, .reg_wr_i, .reg_gsel_i, .reg_idx_i,
  .reg_wdata_i, .desc_req_o, .desc_valid_i, .desc_addr_o, .mbox_evt_i,
  .gpio_wake_i, .codec_wake_i, .master_abort_i, .target_abort_i,
  .inta_n_o, .pci_retry_o, .func_count_o, .cfg_locked_o
);

// File: tb/hmd_host_model.sv
// Behavioural host memory: answers descriptor reads and data beats.
// Assumes the testbench loads mem and drives the stall input.
`timescale 1ns/1ps
module hmd_host_model (
  // Clock and reset
  input  logic        core_clk_i,
  input  logic        arst_n_i,
  input  logic        stall_i,
  // Data beats
  input  logic [3:0]  req_i,
  output logic [3:0]  done_o,
  output logic [2:0]  bytes_o,
  // Descriptor reads
  input  logic        dreq_i,
  input  logic [31:0] daddr_i,
  output logic        dvalid_o,
  output logic [31:0] ddata_o
);
  logic [31:0] mem [0:31];

  // One four-byte beat to the lowest requesting channel
  always_ff @(posedge core_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      done_o <= 4'h0;
    else if (req_i != 4'h0 && done_o == 4'h0 && !stall_i)
      done_o <= req_i & (~req_i + 4'h1);
    else
      done_o <= 4'h0;
  assign bytes_o = (done_o != 4'h0) ? 3'h4 : 3'h3; // Idle shows inverse

  // Descriptor words by word address; idle data toggles
  always_ff @(posedge core_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      dvalid_o <= 1'b0;
      ddata_o  <= 32'h0;
    end
    else if (dreq_i && !dvalid_o && !stall_i)
    begin
      dvalid_o <= 1'b1;
      ddata_o  <= mem[daddr_i[6:2]];
    end
    else
    begin
      dvalid_o <= 1'b0;
      ddata_o  <= ~ddata_o;
    end
endmodule // hmd_host_model

// File: tb/tb_pci_master_dma_sg_interrupts.sv
// Testbench for the DMA engine: registers, events, both channel modes.
// Assumes hmd_pkg, the checker and the host model are compiled first.
`timescale 1ns/1ps
`include "hmd_defs.svh"
module tb_pci_master_dma_sg_interrupts
  import hmd_pkg::*;
;
  typedef struct {logic [31:0] e; logic [31:0] m; string n;} hmd_exp_t;
  localparam logic [31:0] FF = 32'hffff_ffff;
  hmd_exp_t    exp_q[$];
  hmd_exp_t    h;
  logic        core_clk_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic        reg_gsel_i = 0, hold = 1, stall = 1, rd_q = 0;
  logic [1:0]  reg_chan_i = 0, desc_chan_o, func_count_o;
  logic [2:0]  reg_idx_i = 0, beat_bytes_i;
  logic [31:0] reg_wdata_i = 0, reg_rdata_o, last_rd, base;
  logic [31:0] desc_addr_o, desc_data_i, beat_addr_o;
  logic [7:0]  ev = 0;
  logic [3:0]  beat_req_o, beat_done_i;
  logic        desc_req_o, desc_valid_i, inta_n_o, pci_retry_o;
  logic        cfg_locked_o;
  int          err_total = 0, checked = 0, cyc = 0, seed = 11228, k;
  int          pos[8] = '{5, 6, 7, 8, 11, 12, 13, 14};

  // ****************************************************************
  // Design, host model, clock
  // ****************************************************************
  hmd_engine dut (
    .core_clk_i, .arst_n_i, .reg_wr_i, .reg_rd_i, .reg_gsel_i,
    .reg_chan_i, .reg_idx_i, .reg_wdata_i, .reg_rdata_o, .beat_req_o,
    .beat_addr_o, .beat_done_i, .beat_bytes_i, .desc_req_o,
    .desc_chan_o, .desc_addr_o, .desc_valid_i, .desc_data_i,
    .mbox_evt_i(ev[3:0]), .gpio_wake_i(ev[4]), .codec_wake_i(ev[5]),
    .master_abort_i(ev[6]), .target_abort_i(ev[7]), .inta_n_o,
    .pci_retry_o, .func_count_o, .cfg_locked_o);
  hmd_host_model host (
    .core_clk_i, .arst_n_i, .stall_i(stall), .req_i(beat_req_o),
    .done_o(beat_done_i), .bytes_o(beat_bytes_i), .dreq_i(desc_req_o),
    .daddr_i(desc_addr_o), .dvalid_o(desc_valid_i), .ddata_o(desc_data_i));
  always #2.5 core_clk_i = ~core_clk_i;
  // Random host stalls unless held
  always @(negedge core_clk_i) stall <= hold || ($random(seed) % 4 == 0);

  // ****************************************************************
  // Register tasks, read monitor, verdict
  // ****************************************************************
  task wr(input logic g, input logic [1:0] c, input logic [2:0] i,
          input logic [31:0] d);
    @(negedge core_clk_i);
    {reg_gsel_i, reg_chan_i, reg_idx_i, reg_wdata_i} = {g, c, i, d};
    reg_wr_i = 1;
    @(negedge core_clk_i);
    reg_wr_i = 0;
  endtask
  task rd(input logic g, input logic [1:0] c, input logic [2:0] i,
          input logic [31:0] e, input logic [31:0] m, input string n);
    exp_q.push_back('{e, m, n});
    @(negedge core_clk_i);
    {reg_gsel_i, reg_chan_i, reg_idx_i} = {g, c, i};
    reg_rd_i = 1;
    @(negedge core_clk_i);
    reg_rd_i = 0;
    @(posedge core_clk_i);
    #1;
  endtask
  task poll(input logic [1:0] c, input logic [31:0] m, input logic [31:0] w);
    int i;
    last_rd = ~w & m;
    for (i = 0; i < 300 && (last_rd & m) !== w; i++)
      rd(0, c, `HMD_R_CTRL, 0, 0, "poll");
    if ((last_rd & m) !== w)
    begin
      err_total++;
      $display("wrong value poll expected %h seen %h", w, last_rd & m);
    end
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task print_verdict;
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Compare each read answer with the oldest note
  always @(posedge core_clk_i)
  begin
    if (rd_q)
    begin
      h = exp_q.pop_front();
      last_rd = reg_rdata_o;
      if (h.m != 0)
      begin
        checked++;
        if ((reg_rdata_o & h.m) !== (h.e & h.m))
        begin
          err_total++;
          $display("wrong value %s expected %h seen %h", h.n, h.e & h.m,
                   reg_rdata_o & h.m);
        end
      end
    end
    rd_q <= reg_rd_i;
  end
  // Cycle ceiling
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      print_verdict;
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    repeat (16) @(negedge core_clk_i);
    arst_n_i = 1;
    rd(1, 0, `HMD_G_IRQ_FLAGS, 0, FF, "flags");
    rd(1, 0, `HMD_G_LINK_CTRL, 0, FF, "link");
    rd(1, 0, 3'h7, 0, FF, "unmapped");
    chk("retry", 1, pci_retry_o);
    chk("inta", 1, inta_n_o);
    // Each non-channel source sets its flag; zero keeps it, one clears it
    for (k = 0; k < 8; k++)
    begin
      @(negedge core_clk_i) ev = 8'h1 << k;
      @(negedge core_clk_i) ev = 0;
      rd(1, 0, 0, 32'h1 << pos[k], FF, "flags");
      chk("inta", 0, inta_n_o);
      wr(1, 0, 0, 0);
      rd(1, 0, 0, 32'h1 << pos[k], FF, "flags");
      wr(1, 0, 0, 32'hffff);
      rd(1, 0, 0, 0, FF, "flags");
      chk("inta", 1, inta_n_o);
    end
    // Circular looping buffer on every channel
    for (k = 0; k < 4; k++)
    begin
      hold = 0;
      base = $random(seed) & 32'h0000_fff0;
      wr(0, k[1:0], `HMD_R_BASE_ADDR, base);
      wr(0, k[1:0], `HMD_R_CUR_ADDR, base);
      wr(0, k[1:0], `HMD_R_BASE_CNT, 16);
      wr(0, k[1:0], `HMD_R_CUR_CNT, 16);
      wr(0, k[1:0], `HMD_R_IRQ_BASE, 8);
      wr(0, k[1:0], `HMD_R_IRQ_CNT, 8);
      wr(0, k[1:0], `HMD_R_CTRL, 32'h25);
      poll(k[1:0], 32'h100, 32'h100);
      hold = 1;
      rd(0, k[1:0], `HMD_R_CTRL, 32'h1100, 32'h1100, "ctrl");
      wr(0, k[1:0], `HMD_R_CTRL, 32'h0f00);
      rd(0, k[1:0], `HMD_R_CTRL, 0, 32'h1f00, "ctrl");
      rd(0, k[1:0], `HMD_R_CUR_CNT, 0, 0, "cnt");
      rd(0, k[1:0], `HMD_R_CUR_ADDR, base + 32'd16 - {8'h0, last_rd[23:0]},
         FF, "addr");
      if (k == 0)
        chk("beat addr", last_rd, beat_addr_o);
      rd(1, 0, 0, 32'h2 << k, 32'h2 << k, "flags");
      wr(1, 0, 0, 32'h2 << k);
      rd(1, 0, 0, 0, 32'h2 << k, "flags");
    end
    // Two-entry descriptor table at 0x40, flag then end marker
    hold = 0;
    host.mem[16] = 32'h0000_2000;
    host.mem[17] = 32'h4000_0008;
    host.mem[18] = 32'h0000_3000;
    host.mem[19] = 32'h8000_0004;
    wr(0, 2, `HMD_R_BASE_ADDR, 32'h40);
    wr(0, 2, `HMD_R_CTRL, 32'h1b);
    poll(2, 32'h1000, 0);
    chk("desc chan", 2, desc_chan_o);
    rd(0, 2, `HMD_R_CTRL, 32'h0700, 32'h1700, "ctrl");
    rd(0, 2, `HMD_R_CUR_ADDR, 32'h48, FF, "ptr");
    rd(1, 0, 0, 32'h8, 32'h8, "flags");
    wr(0, 2, `HMD_R_CTRL, 32'h0f00);
    wr(1, 0, 0, 32'hffff);
    // Function count, ready bit, then lock
    wr(1, 0, `HMD_G_LINK_CTRL, 1);
    rd(1, 0, `HMD_G_LINK_CTRL, 1, FF, "link");
    chk("func", 1, func_count_o);
    chk("retry", 1, pci_retry_o);
    wr(1, 0, `HMD_G_LINK_CTRL, 6);
    rd(1, 0, `HMD_G_LINK_CTRL, 6, FF, "link");
    chk("lock", 1, cfg_locked_o);
    chk("retry", 0, pci_retry_o);
    wr(1, 0, `HMD_G_LINK_CTRL, 0);
    rd(1, 0, `HMD_G_LINK_CTRL, 6, FF, "link");
    chk("func", 2, func_count_o);
    repeat (2) @(posedge core_clk_i);
    print_verdict;
  end
endmodule // tb_pci_master_dma_sg_interrupts
